// ==== rtl/adc_serial_pkg.sv ====
package adc_serial_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 10;    // System clock rate in MHz.
  localparam int unsigned CONV_TIME_NS  = 8000;  // Longest conversion time.
  localparam int unsigned CONV_CYC      = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned MCLK_HALF_NS  = 200;   // Master clock half period.
  localparam int unsigned MCLK_HALF_CYC = (MCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RES_BITS      = 16;    // Result width.
  localparam int unsigned FRAME_CYC     = 2 * RES_BITS * MCLK_HALF_CYC;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS  = 12'h004;
  localparam logic [11:0] RES_OFS   = 12'h008;
  localparam int unsigned CTRL_SCLK_INV = 0;
  localparam int unsigned CTRL_FRM_INV  = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  // ---------------------------------------------------------------
  // Synchronised pin positions and their idle reset levels
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 9;
  localparam int unsigned P_SCLK = 0;
  localparam int unsigned P_CS   = 1;
  localparam int unsigned P_RD   = 2;
  localparam int unsigned P_CHN  = 3;
  localparam int unsigned P_CNV  = 4;
  localparam int unsigned P_RT   = 5;
  localparam int unsigned P_CSEL = 6;
  localparam int unsigned P_ISEL = 7;
  localparam int unsigned P_PD   = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h016;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_CONV = 2'b01,
    CV_HOLD = 2'b10
  } conv_state_t;

endpackage

// ==== rtl/adc_serial_readout_port.sv ====
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Source select low: device makes serial clock.
// - Master drives frame-valid strobe during data.
// - Clock and frame polarity each selectable.
// - Master read timing: after or during conversion.
// - Master after-conversion: busy spans 16 bits.
// - Source select high: host supplies serial clock.
// - Slave clock gated; read when select, enable low.
// - Continuous or gapped clock, either idle level.
// - Slave after-conversion: 16 bits, MSB first.
// - Slave after-conversion clock up to 40 MHz; here sampled by the 10 MHz sys_clk.
// - Chain input only in slave after-conversion.
// - Chain sampled opposite edge, follows last bit.
// - Slave during-conversion: previous result, MSB first.
// - Late read pulses the late-read flag.
// - Read may straddle into the next conversion.
// - Interface select high enables serial port.
// - Select or enable high: outputs high impedance.
// - Conversion cannot be restarted or aborted.
module adc_serial_readout_port
  import adc_serial_pkg::*;
(
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // APB slave.
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Converter core.
  input  wire logic          convertStartN,
  input  wire logic          powerDownIn,
  input  wire logic [15:0]   sampleData,
  output logic               busy,
  // Serial pins.
  input  wire logic          interfaceSelect,
  input  wire logic          clockSourceSelect,
  input  wire logic          readTimingChainIn,
  input  wire logic          csN,
  input  wire logic          rdN,
  input  wire logic          sclkIn,
  output logic               sclkOut,
  output logic               sclkOeN,
  output logic               serialResultOut,
  output logic               serialResultOeN,
  output logic               frameValid,
  output logic               frameValidOeN,
  output logic               lateReadFlag
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_sync_if pins ();

  assign pins.raw = {powerDownIn, interfaceSelect, clockSourceSelect,
                     readTimingChainIn, convertStartN, readTimingChainIn,
                     rdN, csN, sclkIn};

  pin_sync u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pins    (pins.syncer)
  );

  logic sclkS;     // Filtered external serial clock.
  logic csS;       // Filtered device select, active low.
  logic rdS;       // Filtered read enable, active low.
  logic chainS;    // Filtered chain input.
  logic convS;     // Filtered convert start, active low.
  logic rdcS;      // Read timing: high reads during conversion.
  logic cselS;     // Clock source select.
  logic serOn;     // Serial port chosen.
  logic pdS;       // Power-down request.

  assign sclkS  = pins.clean[P_SCLK];
  assign csS    = pins.clean[P_CS];
  assign rdS    = pins.clean[P_RD];
  assign chainS = pins.clean[P_CHN];
  assign convS  = pins.clean[P_CNV];
  assign rdcS   = pins.clean[P_RT];
  assign cselS  = pins.clean[P_CSEL];
  assign serOn  = pins.clean[P_ISEL];
  assign pdS    = pins.clean[P_PD];

  logic master;    // Device makes the serial clock.
  logic selected;  // Select and read enable both low.

  assign master   = ~cselS;
  assign selected = ~csS & ~rdS;

  // ---------------------------------------------------------------
  // Edge detection on cleaned levels
  // ---------------------------------------------------------------
  logic sclkPrev;  // Last external clock level.
  logic convPrev;  // Last convert start level.

  // Both edges are found, so a gapped clock idling high or low and a
  // free-running clock are treated alike.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev <= 1'b0;
      convPrev <= 1'b1;
    end else begin
      sclkPrev <= sclkS;
      convPrev <= convS;
    end
  end

  logic sclkRise;  // External clock rising edge.
  logic sclkFall;  // External clock falling edge.
  logic convFall;  // Convert start asserted.

  assign sclkRise = sclkS & ~sclkPrev;
  assign sclkFall = ~sclkS & sclkPrev;
  assign convFall = ~convS & convPrev;

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  conv_state_t convState_reg;  // Current state.
  conv_state_t convState_next; // Next state.
  logic [7:0]  convCnt_reg;    // Cycles into the conversion.
  logic        convStart;      // Accepted start.
  logic        convEnd;        // Last conversion cycle.
  logic        mDone;          // Master transfer finished.

  // A start is taken only when idle; starts during a conversion are
  // dropped and power-down cannot cut one short.
  assign convStart = convFall & (convState_reg == CV_IDLE) & ~pdS;
  assign convEnd   = (convState_reg == CV_CONV) &&
                     (convCnt_reg == 8'(CONV_CYC - 1));

  // Next-state selection.
  always_comb begin
    convState_next = convState_reg;
    case (convState_reg)
      CV_IDLE: begin
        if (convStart) begin
          convState_next = CV_CONV;
        end
      end
      CV_CONV: begin
        // Master after-conversion keeps busy until the bits are out.
        if (convEnd) begin
          if (serOn && master && !rdcS) begin
            convState_next = CV_HOLD;
          end else begin
            convState_next = CV_IDLE;
          end
        end
      end
      CV_HOLD: begin
        if (mDone) begin
          convState_next = CV_IDLE;
        end
      end
      default: begin
        convState_next = CV_IDLE;
      end
    endcase
  end

  // State and cycle counter.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      convState_reg <= CV_IDLE;
      convCnt_reg   <= 8'h00;
    end else begin
      convState_reg <= convState_next;
      if (convState_reg == CV_CONV) begin
        convCnt_reg <= convCnt_reg + 8'h01;
      end else begin
        convCnt_reg <= 8'h00;
      end
    end
  end

  // Busy tracks the state to come, so it leaves a flip-flop in step.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= (convState_next != CV_IDLE);
    end
  end

  // Latest result, kept for reads during the following conversion.
  logic [15:0] result_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= 16'h0000;
    end else if (convEnd) begin
      result_reg <= sampleData;
    end
  end

  // ---------------------------------------------------------------
  // Master clock divider
  // ---------------------------------------------------------------
  logic [3:0] divCnt_reg;  // Counts one half period.
  logic       mTick;       // One-cycle enable per half period.
  logic       load;        // Fresh word enters the shifter.

  assign mTick = (divCnt_reg == 4'(MCLK_HALF_CYC - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 4'h0;
    end else if (mTick || load) begin
      // Restarting on a load fixes the divider phase, so every frame
      // lasts the same number of cycles.
      divCnt_reg <= 4'h0;
    end else begin
      divCnt_reg <= divCnt_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  logic [15:0] shiftReg;   // Outgoing bits, MSB leaves first.
  logic [4:0]  bitCnt;     // Bits shifted out so far.
  logic        mActive;    // Master transfer in progress.
  logic        sclkInt;    // Generated clock, true polarity.
  logic        pending;    // Slave result not yet fully read.
  logic        chainBit;   // Chain input caught on rising edge.
  logic [15:0] loadVal;    // Word to be loaded.
  logic        slaveAct;   // Slave shifting allowed.
  logic        sFall;      // Slave shift edge.

  // Master during-conversion sends the previous word at the start;
  // every other mode sends the new word once the conversion ends.
  assign load    = serOn & (master ? (rdcS ? convStart : convEnd)
                                   : convEnd);
  assign loadVal = (master & rdcS) ? result_reg : sampleData;
  assign slaveAct = serOn & ~master & selected;
  assign sFall    = slaveAct & sclkFall & ~load;
  assign mDone    = mTick & mActive & sclkInt & (bitCnt == 5'd15);

  // Chain data is caught on the edge opposite the shift edge.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chainBit <= 1'b0;
    end else if (slaveAct && sclkRise) begin
      chainBit <= chainS;
    end
  end

  // Shifter, bit counter and master clock generation.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shiftReg <= 16'h0000;
      bitCnt   <= 5'd0;
      mActive  <= 1'b0;
      sclkInt  <= 1'b0;
    end else if (load) begin
      shiftReg <= loadVal;
      bitCnt   <= 5'd0;
      mActive  <= master;
      sclkInt  <= 1'b0;
    end else if (master) begin
      // Data moves on the falling edge; the host samples on rising.
      if (mTick && mActive) begin
        if (!sclkInt) begin
          sclkInt <= 1'b1;
        end else begin
          sclkInt  <= 1'b0;
          shiftReg <= {shiftReg[14:0], 1'b0};
          bitCnt   <= bitCnt + 5'd1;
          if (bitCnt == 5'd15) begin
            mActive <= 1'b0;
          end
        end
      end
    end else if (sFall) begin
      // Chain data fills in behind the last bit; it is ignored when
      // reading during conversion, where no chain exists.
      shiftReg <= {shiftReg[14:0], rdcS ? 1'b0 : chainBit};
      if (bitCnt != 5'd16) begin
        bitCnt <= bitCnt + 5'd1;
      end
    end
  end

  // Pending read tracking; a new load wins over the final bit.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
    end else if (load && !master) begin
      pending <= 1'b1;
    end else if (sFall && bitCnt == 5'd15) begin
      pending <= 1'b0;
    end
  end

  // Late read: the previous word was not fully read when the next
  // conversion completed, so the host sees a one-cycle pulse.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lateReadFlag <= 1'b0;
    end else begin
      lateReadFlag <= serOn & ~master & rdcS & convEnd & pending;
    end
  end

  // ---------------------------------------------------------------
  // Control register and pin drivers
  // ---------------------------------------------------------------
  logic [1:0] ctrl_reg;  // Polarity inversion bits.

  // All interface outputs float while select or read enable is high
  // or the serial port is not chosen. The enables are active low.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serialResultOut <= 1'b0;
      serialResultOeN <= 1'b1;
      sclkOut         <= 1'b0;
      sclkOeN         <= 1'b1;
      frameValid      <= 1'b0;
      frameValidOeN   <= 1'b1;
    end else begin
      serialResultOut <= shiftReg[15];
      serialResultOeN <= ~(serOn & selected);
      sclkOut         <= sclkInt ^ ctrl_reg[CTRL_SCLK_INV];
      sclkOeN         <= ~(serOn & master & selected);
      frameValid      <= mActive ^ ctrl_reg[CTRL_FRM_INV];
      frameValidOeN   <= ~(serOn & master & selected);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic       apbAcc;   // Access phase, answer not yet given.
  logic       apbDone;  // Completing edge.
  logic       mapped;   // Address hits a register.

  assign apbAcc  = psel & penable & ~pready;
  assign apbDone = psel & penable & pready;
  assign mapped  = (paddr == CTRL_OFS) | (paddr == STAT_OFS) |
                   (paddr == RES_OFS);

  // One wait state: read data and the answer settle together.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbAcc;
      pslverr <= apbAcc & ~mapped;
      prdata  <= 32'h0000_0000;
      if (apbAcc && !pwrite) begin
        case (paddr)
          CTRL_OFS: prdata <= {30'h0, ctrl_reg};
          STAT_OFS: prdata <= {27'h0, pending, master, mActive,
                               convState_reg != CV_IDLE, busy};
          RES_OFS:  prdata <= {16'h0000, result_reg};
          default:  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land on the edge where the master sees pready high.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
    end else if (apbDone && pwrite && paddr == CTRL_OFS) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [6:0] frmCnt;  // Cycles of the current master frame.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frmCnt <= 7'd0;
    end else if (!mActive) begin
      frmCnt <= 7'd0;
    end else begin
      frmCnt <= frmCnt + 7'd1;
    end
  end

  sequence s_mac_end;
    convEnd && serOn && master && !rdcS;
  endsequence

  sequence s_slave_shift;
    sFall && !rdcS;
  endsequence

  a_busy_rac_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    s_mac_end |=> busy && (convState_reg == CV_HOLD))
    else $error("busy fell before master bits were sent");

  a_frame_length: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(mActive) |-> ($past(frmCnt) == 7'(FRAME_CYC - 1)))
    else $error("master frame length wrong");

  a_sclk_idle: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !mActive |-> !sclkInt)
    else $error("master clock moved outside a frame");

  a_late_cause: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    lateReadFlag |-> $past(convEnd) && $past(pending) ##1 !lateReadFlag)
    else $error("late read flag without cause or too long");

  a_hiz_deselect: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (csS || rdS) |=> serialResultOeN && sclkOeN && frameValidOeN)
    else $error("outputs driven while not selected");

  a_no_restart: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (convState_reg == CV_CONV) && !convEnd |=>
      (convState_reg == CV_CONV) && (convCnt_reg != 8'h00))
    else $error("conversion restarted or aborted");

  a_chain_follow: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    s_slave_shift |=> shiftReg[0] == $past(chainBit))
    else $error("chain bit not shifted in behind last bit");

  a_msb_first: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    load |=> shiftReg == $past(loadVal) ##1 serialResultOut == shiftReg[15] || load)
    else $error("loaded word or first bit wrong");

endmodule

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
  import adc_serial_pkg::*;
(
  // Clock and reset.
  input wire logic   sys_clk,
  input wire logic   rstn,
  // Pin levels.
  pin_sync_if.syncer pins
);

  // ---------------------------------------------------------------
  // Three-stage synchroniser per pin
  // ---------------------------------------------------------------
  // A change is accepted only when stages two and three agree, so a
  // single metastable sample never reaches the logic.
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic [2:0] stage;  // Stage 0 feeds stage 1 only.
      logic       cleanBit;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          stage    <= {3{SYNC_RST[i]}};
          cleanBit <= SYNC_RST[i];
        end else begin
          stage <= {stage[1:0], pins.raw[i]};
          if (stage[1] == stage[2]) begin
            cleanBit <= stage[2];
          end
        end
      end
      assign pins.clean[i] = cleanBit;
    end
  endgenerate

endmodule

// ==== rtl/pin_sync_if.sv ====
`timescale 1ns/1ps
// Raw pin levels in, cleaned levels out.
interface pin_sync_if;
  import adc_serial_pkg::*;
  logic [SYNC_W-1:0] raw;    // Levels straight from the pins.
  logic [SYNC_W-1:0] clean;  // Filtered levels in the sys_clk domain.
  modport syncer (input raw, output clean);
  modport user   (output raw, input clean);
endinterface

// ==== tb/adc_serial_readout_port_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module adc_serial_readout_port_tb;
  import adc_serial_pkg::*;
  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er, convertStartN, powerDownIn, busy, interfaceSelect;
  logic [15:0] sampleData;
  logic        clockSourceSelect, readTimingChainIn, csN, rdN, sclkIn;
  logic        sclkOut, sclkOeN, serialResultOut, serialResultOeN;
  logic        frameValid, frameValidOeN, lateReadFlag;
  logic [16:0] w;
  int          failures, comparisons, cycles, lateCnt;

  adc_serial_readout_port i_adc_serial_readout_port (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convertStartN(convertStartN), .powerDownIn(powerDownIn), .sampleData(sampleData), .busy(busy),
    .interfaceSelect(interfaceSelect), .clockSourceSelect(clockSourceSelect), .readTimingChainIn(readTimingChainIn),
    .csN(csN), .rdN(rdN), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOeN(sclkOeN), .serialResultOut(serialResultOut),
    .serialResultOeN(serialResultOeN), .frameValid(frameValid), .frameValidOeN(frameValidOeN),
    .lateReadFlag(lateReadFlag));
  host_model i_host_model (.sclkHost(sclkIn), .sdoIn(serialResultOut));

  // Clock, and a watchdog so a hang still reaches the verdict.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    lateCnt += (lateReadFlag === 1'b1);
    if (cycles == 20000) begin
      failures++;
      wrap_up;
    end
  end

  task wrap_up;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Starts one conversion and waits for busy to end, under a bound.
  task automatic convert;
    int n;
    n = 0;
    @(posedge sys_clk);
    convertStartN <= 1'b0;
    repeat (8) @(posedge sys_clk);
    convertStartN <= 1'b1;
    while (busy !== 1'b0 && n < 400) begin @(posedge sys_clk); n++; end
  endtask

  // Master frame: bits taken on clock rises while the strobe is active.
  task automatic master_run(input logic inv, input logic during, input logic [15:0] exp);
    logic [15:0] got;
    logic        pk, ck;
    logic [1:0]  fh;
    int          fv, outside, blen;
    got = '0; pk = 1'b0; fh = 2'b00; fv = 0; outside = 0; blen = 0;
    apb(1'b1, CTRL_OFS, {30'h0, inv, inv});
    readTimingChainIn <= during;
    repeat (8) @(posedge sys_clk);
    convertStartN <= 1'b0;
    for (int c = 0; c < 400; c++) begin
      @(posedge sys_clk);
      if (c == 8) convertStartN <= 1'b1;
      ck = sclkOut ^ inv;
      fh = {fh[0], frameValid ^ inv};
      if (fh[0]) fv++;
      if (fh[0] && ck && !pk) got = {got[14:0], serialResultOut};
      if (fh == 2'b00 && ck) outside++;
      pk = ck;
      if (busy === 1'b1) blen++;
      if (c > 20 && busy === 1'b0) break;
    end
    `CHK(got, exp)
    `CHK(fv, FRAME_CYC)
    `CHK(outside, 0)
    `CHK(sclkOeN, 1'b0)
    if (!during) `CHK(blen > CONV_CYC + FRAME_CYC / 2, 1'b1)
    $display("master test done inv=%0d during=%0d", inv, during);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, powerDownIn, csN, rdN} = '0;
    {failures, comparisons, cycles, lateCnt} = '0;
    {convertStartN, interfaceSelect} = 2'b11;
    clockSourceSelect = 1'b0;
    readTimingChainIn = 1'b0;
    sampleData = 16'ha5c3;
    rstn = 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    // Register access, including a refused address.
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, {30'h0, CTRL_RST})
    apb(1'b0, 12'hffc, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("register test done");
    // Master read after, then read during with the old result.
    master_run(1'b0, 1'b0, 16'ha5c3);
    sampleData <= 16'h3c5b;
    master_run(1'b1, 1'b1, 16'ha5c3);
    apb(1'b0, RES_OFS, 32'h0);
    `CHK(rd[15:0], 16'h3c5b)
    // Slave read after conversion with a chain bit trailing.
    apb(1'b1, CTRL_OFS, 32'h0);
    clockSourceSelect <= 1'b1;
    readTimingChainIn <= 1'b0;
    convert;
    i_host_model.read_bits(17, 1'b0, w);
    `CHK(w[16:1], 16'h3c5b)
    `CHK(w[0], 1'b0)
    `CHK({sclkOeN, frameValidOeN}, 2'b11)
    $display("slave after test done");
    // Slave read during: straddled read is clean, a skipped read is late.
    readTimingChainIn <= 1'b1;
    sampleData <= 16'h9e17;
    convert;
    sampleData <= 16'h0001;
    fork
      i_host_model.read_bits(16, 1'b1, w);
      begin #6400; convert; end
    join
    `CHK(w[15:0], 16'h9e17)
    `CHK(lateCnt, 0)
    convert;
    repeat (4) @(posedge sys_clk);
    `CHK(lateCnt, 1)
    $display("slave during test done");
    // The result output enable follows both selects and the interface select.
    csN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(serialResultOeN, 1'b1)
    csN <= 1'b0;
    rdN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(serialResultOeN, 1'b1)
    rdN <= 1'b0;
    interfaceSelect <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK(serialResultOeN, 1'b1)
    interfaceSelect <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(serialResultOeN, 1'b0)
    $display("enable test done");
    wrap_up;
  end
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host serial port model
// ---------------------------------------------------------------
module host_model (
  // Link pins.
  output logic      sclkHost,
  input  wire logic sdoIn
);
  // The host clock stands still between frames.
  initial sclkHost = 1'b0;

  // Gapped 800 ns clock; each bit is taken just before its falling edge.
  // Either idle level is offered, since the port must accept both.
  task automatic read_bits(input int n, input logic idleHigh, output logic [16:0] word);
    word = '0;
    sclkHost = idleHigh;
    #400;
    for (int i = 0; i < n; i++) begin
      if (!idleHigh) begin
        sclkHost = 1'b1;
        #400;
      end
      word = {word[15:0], sdoIn};
      sclkHost = 1'b0;
      #400;
      if (idleHigh) begin
        sclkHost = 1'b1;
        #400;
      end
    end
  endtask
endmodule
